// File: fspc_pkg.sv
// shared constants and types for the flash self-programming controller
package fspc_pkg;
  // apb register byte offsets
  localparam logic [7:0] FSPC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] FSPC_OFS_KEY = 8'h04;
  localparam logic [7:0] FSPC_OFS_TPAGE = 8'h08;
  // flash_op_control field positions
  localparam int FSPC_BIT_START = 15;
  localparam int FSPC_BIT_PENABLE = 14;
  localparam int FSPC_BIT_SEQERR = 13;
  localparam int FSPC_BIT_ERASE = 6;
  localparam int FSPC_OPSEL_MSB = 3;
  // reset values
  localparam logic [3:0] FSPC_RST_OPSEL = 4'h0;
  localparam logic [7:0] FSPC_RST_TPAGE = 8'h00;
  // unlock values
  localparam logic [7:0] FSPC_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSPC_KEY_SECOND = 8'haa;
  // operation_select encodings
  localparam logic [3:0] FSPC_SEL_BULK = 4'hf;
  localparam logic [3:0] FSPC_SEL_GENSEG = 4'hd;
  localparam logic [3:0] FSPC_SEL_C3 = 4'h3;
  localparam logic [3:0] FSPC_SEL_PAGE = 4'h2;
  localparam logic [3:0] FSPC_SEL_C1 = 4'h1;
  localparam logic [3:0] FSPC_SEL_CFG = 4'h0;
  // geometry in program address units (two per instruction)
  localparam logic [23:0] FSPC_PAGE_MASK = 24'hfffc00;
  localparam logic [23:0] FSPC_ROW_MASK = 24'hffff80;
  localparam logic [23:0] FSPC_WORD_MASK = 24'hfffffe;
  localparam int FSPC_BUF_WORDS = 64;
  // durations in internal_rc_osc cycles
  localparam int FSPC_ROW_OSC_CYCLES = 11064;
  localparam int FSPC_PAGE_OSC_CYCLES = 11064;
  localparam int FSPC_WORD_OSC_CYCLES = 1024;
  localparam int FSPC_BULK_OSC_CYCLES = 11064;
  localparam int FSPC_CFG_OSC_CYCLES = 1024;
  localparam int FSPC_CNT_W = 16;

  typedef enum logic [3:0] {
    FSPC_OP_NONE = 4'b0000,
    FSPC_OP_BULK = 4'b0001,
    FSPC_OP_GENSEG = 4'b0010,
    FSPC_OP_PAGE = 4'b0011,
    FSPC_OP_CFG_ERASE = 4'b0100,
    FSPC_OP_WORD = 4'b0101,
    FSPC_OP_ROW = 4'b0110,
    FSPC_OP_CFG_PROG = 4'b0111,
    FSPC_OP_UNIMP = 4'b1000
  } fspc_op_t;

  typedef enum logic [1:0] {
    FSPC_KEY_NONE = 2'b00,
    FSPC_KEY_HALF = 2'b01,
    FSPC_KEY_OPEN = 2'b10
  } fspc_key_t;
endpackage : fspc_pkg

// File: fspc_ctrl.sv
// flash self-programming controller: apb registers, table port, holding buffer, op timer
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int ROW_OSC_CYCLES = FSPC_ROW_OSC_CYCLES,
  parameter int PAGE_OSC_CYCLES = FSPC_PAGE_OSC_CYCLES,
  parameter int BULK_OSC_CYCLES = FSPC_BULK_OSC_CYCLES
) (
  input wire logic pclk, // bus clock, 125 mhz
  input wire logic presetn, // bus reset, async active low
  input wire logic por_n, // power-on reset, async active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic tbl_req, // table op request, one cycle
  input wire logic tbl_write, // 1 write, 0 read
  input wire logic tbl_high, // 1 high op, 0 low op
  input wire logic tbl_byte, // byte mode
  input wire logic [15:0] tbl_ea, // effective_addr from working register
  input wire logic [15:0] tbl_wdata, // table write data
  output logic [15:0] tbl_rdata, // table read data
  output logic tbl_ack, // table op done, one cycle
  output logic cpu_stall, // processor stall while op runs
  output logic [23:0] fl_raddr, // array read address
  output logic fl_cfg_space, // access targets configuration space
  input wire logic [23:0] fl_rdata, // array read word, valid cycle after fl_raddr
  output logic fl_op_active, // array operation running
  output logic [3:0] fl_op, // running operation kind
  output logic [23:0] fl_addr, // aligned operation address
  input wire logic [5:0] buf_idx, // holding buffer read index from array
  output logic [23:0] buf_rdata, // holding buffer word, one cycle later
  input wire logic osc_in // internal_rc_osc clock seen as a level
);

  function automatic fspc_op_t fspc_decode(input logic erase, input logic [3:0] sel);
    fspc_op_t op;
    op = FSPC_OP_UNIMP;
    if (erase) begin
      unique case (sel)
        FSPC_SEL_BULK: op = FSPC_OP_BULK;
        FSPC_SEL_GENSEG: op = FSPC_OP_GENSEG;
        FSPC_SEL_PAGE: op = FSPC_OP_PAGE;
        FSPC_SEL_CFG: op = FSPC_OP_CFG_ERASE;
        FSPC_SEL_C3, FSPC_SEL_C1: op = FSPC_OP_NONE;
        default: op = FSPC_OP_UNIMP;
      endcase
    end else begin
      unique case (sel)
        FSPC_SEL_C3: op = FSPC_OP_WORD;
        FSPC_SEL_C1: op = FSPC_OP_ROW;
        FSPC_SEL_CFG: op = FSPC_OP_CFG_PROG;
        FSPC_SEL_BULK, FSPC_SEL_GENSEG, FSPC_SEL_PAGE: op = FSPC_OP_NONE;
        default: op = FSPC_OP_UNIMP;
      endcase
    end
    return op;
  endfunction : fspc_decode

  function automatic logic [FSPC_CNT_W-1:0] fspc_last(input fspc_op_t op);
    logic [FSPC_CNT_W-1:0] n;
    n = FSPC_CNT_W'(FSPC_WORD_OSC_CYCLES - 1);
    unique case (op)
      FSPC_OP_ROW: n = FSPC_CNT_W'(ROW_OSC_CYCLES - 1);
      FSPC_OP_PAGE, FSPC_OP_GENSEG: n = FSPC_CNT_W'(PAGE_OSC_CYCLES - 1);
      FSPC_OP_BULK: n = FSPC_CNT_W'(BULK_OSC_CYCLES - 1);
      FSPC_OP_CFG_ERASE, FSPC_OP_CFG_PROG: n = FSPC_CNT_W'(FSPC_CFG_OSC_CYCLES - 1);
      default: n = FSPC_CNT_W'(FSPC_WORD_OSC_CYCLES - 1);
    endcase
    return n;
  endfunction : fspc_last

  // control register, kept on power-on reset only
  logic start_bit;
  logic program_enable;
  logic sequence_error;
  logic erase_sel;
  logic [3:0] operation_select;
  logic [7:0] table_page;
  fspc_key_t key_state;
  logic [FSPC_CNT_W-1:0] osc_count;
  logic osc_s1, osc_s2, osc_s3;
  logic [23:0] hold_buf [FSPC_BUF_WORDS];
  logic tbl_pend, pend_write, pend_high, pend_byte;
  logic [15:0] pend_ea, pend_wdata;

  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pready && pwrite;
  wire logic wr_ctrl = apb_wr && paddr[7:0] == FSPC_OFS_CONTROL && paddr[31:8] == 24'h0;
  wire logic wr_key = apb_wr && paddr[7:0] == FSPC_OFS_KEY && paddr[31:8] == 24'h0;
  wire logic wr_tpage = apb_wr && paddr[7:0] == FSPC_OFS_TPAGE && paddr[31:8] == 24'h0;
  wire logic set_try = wr_ctrl && pwdata[FSPC_BIT_START] && !start_bit;
  // enable and operation checked against the values written in the same access
  wire fspc_op_t next_op = fspc_decode(pwdata[FSPC_BIT_ERASE], pwdata[FSPC_OPSEL_MSB:0]);
  wire logic start_ok = set_try && key_state == FSPC_KEY_OPEN && pwdata[FSPC_BIT_PENABLE];
  wire logic start_real = start_ok && next_op != FSPC_OP_NONE && next_op != FSPC_OP_UNIMP;
  wire logic osc_tick = osc_s2 && !osc_s3;
  wire logic op_done = start_bit && osc_tick && osc_count == fspc_last(fspc_op_t'(fl_op));
  wire logic [23:0] next_target = {table_page, pend_ea};

  // oscillator crossing: first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      program_enable <= 1'b0;
      erase_sel <= 1'b0;
      operation_select <= FSPC_RST_OPSEL;
    end else if (wr_ctrl && !start_bit) begin
      program_enable <= pwdata[FSPC_BIT_PENABLE];
      erase_sel <= pwdata[FSPC_BIT_ERASE];
      operation_select <= pwdata[FSPC_OPSEL_MSB:0];
    end
  end

  // start bit: set only through a valid unlocked start, cleared only by completion
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      start_bit <= 1'b0;
      fl_op <= FSPC_OP_NONE;
      fl_addr <= 24'h0;
      osc_count <= '0;
    end else if (start_real) begin
      start_bit <= 1'b1;
      fl_op <= next_op;
      osc_count <= '0;
      unique case (next_op)
        FSPC_OP_PAGE: fl_addr <= next_target & FSPC_PAGE_MASK;
        FSPC_OP_ROW: fl_addr <= next_target & FSPC_ROW_MASK;
        default: fl_addr <= next_target & FSPC_WORD_MASK;
      endcase
    end else if (op_done) begin
      start_bit <= 1'b0;
      fl_op <= FSPC_OP_NONE;
    end else if (start_bit && osc_tick) begin
      osc_count <= osc_count + 1'b1;
    end
  end

  // error flag: hardware set wins over a software clear in the same write
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sequence_error <= 1'b0;
    end else if (set_try && !start_ok) begin
      sequence_error <= 1'b1;
    end else if (start_ok) begin
      sequence_error <= 1'b0;
    end else if (wr_ctrl && !start_bit) begin
      sequence_error <= pwdata[FSPC_BIT_SEQERR];
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cpu_stall <= 1'b0;
      fl_op_active <= 1'b0;
    end else begin
      cpu_stall <= start_real || (start_bit && !op_done);
      fl_op_active <= start_real || (start_bit && !op_done);
    end
  end

  // unlock tracker; any other write breaks the consecutive pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state <= FSPC_KEY_NONE;
    end else if (wr_key) begin
      unique case (key_state)
        FSPC_KEY_NONE: key_state <= (pwdata[7:0] == FSPC_KEY_FIRST) ? FSPC_KEY_HALF : FSPC_KEY_NONE;
        FSPC_KEY_HALF: key_state <= (pwdata[7:0] == FSPC_KEY_SECOND) ? FSPC_KEY_OPEN : FSPC_KEY_NONE;
        FSPC_KEY_OPEN: key_state <= (pwdata[7:0] == FSPC_KEY_FIRST) ? FSPC_KEY_HALF : FSPC_KEY_NONE;
        default: key_state <= FSPC_KEY_NONE;
      endcase
    end else if (apb_wr) begin
      key_state <= FSPC_KEY_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_page <= FSPC_RST_TPAGE;
    end else if (wr_tpage) begin
      table_page <= pwdata[7:0];
    end
  end

  // apb slave: one wait-free access phase, data prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_setup) begin
        if (paddr[31:8] != 24'h0) begin
          pslverr <= 1'b1;
        end else begin
          unique case (paddr[7:0])
            FSPC_OFS_CONTROL: prdata <= {16'h0, start_bit, program_enable, sequence_error,
                                         6'h0, erase_sel, 2'h0, operation_select};
            FSPC_OFS_KEY: prdata <= 32'h0;
            FSPC_OFS_TPAGE: prdata <= {24'h0, table_page};
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // table port: request taken, array or buffer touched next edge, ack after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_pend <= 1'b0;
      pend_write <= 1'b0;
      pend_high <= 1'b0;
      pend_byte <= 1'b0;
      pend_ea <= 16'h0;
      pend_wdata <= 16'h0;
      fl_raddr <= 24'h0;
      fl_cfg_space <= 1'b0;
    end else begin
      tbl_pend <= tbl_req && !tbl_pend && !start_bit;
      if (tbl_req && !tbl_pend && !start_bit) begin
        pend_write <= tbl_write;
        pend_high <= tbl_high;
        pend_byte <= tbl_byte;
        pend_ea <= tbl_ea;
        pend_wdata <= tbl_wdata;
        fl_raddr <= {table_page, tbl_ea & 16'hfffe};
        fl_cfg_space <= table_page[7];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= 16'h0;
    end else begin
      tbl_ack <= tbl_pend;
      if (tbl_pend && !pend_write) begin
        if (!pend_high && !pend_byte) begin
          tbl_rdata <= fl_rdata[15:0];
        end else if (!pend_high) begin
          tbl_rdata <= {8'h0, pend_ea[0] ? fl_rdata[15:8] : fl_rdata[7:0]};
        end else begin
          tbl_rdata <= {8'h0, (pend_byte && pend_ea[0]) ? 8'h0 : fl_rdata[23:16]};
        end
      end
    end
  end

  // holding buffer: index from effective address, never the array itself
  always_ff @(posedge pclk) begin
    if (tbl_pend && pend_write) begin
      if (!pend_high && !pend_byte) begin
        hold_buf[pend_ea[6:1]][15:0] <= pend_wdata;
      end else if (!pend_high && pend_ea[0]) begin
        hold_buf[pend_ea[6:1]][15:8] <= pend_wdata[7:0];
      end else if (!pend_high) begin
        hold_buf[pend_ea[6:1]][7:0] <= pend_wdata[7:0];
      end else if (!(pend_byte && pend_ea[0])) begin
        hold_buf[pend_ea[6:1]][23:16] <= pend_wdata[7:0];
      end
    end
    buf_rdata <= hold_buf[buf_idx];
  end

  default clocking fspc_cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);

  // key pair as a master with one idle cycle between transfers sends it
  sequence s_key_first;
    wr_key && pwdata[7:0] == FSPC_KEY_FIRST;
  endsequence

  sequence s_unlock;
    s_key_first ##1 (!apb_wr)[*2] ##1 wr_key && pwdata[7:0] == FSPC_KEY_SECOND;
  endsequence

  property p_launch;
    start_real |=> start_bit && cpu_stall && fl_op_active;
  endproperty
  a_launch: assert property (p_launch) else $error("valid start did not launch");

  property p_need_key;
    set_try && key_state != FSPC_KEY_OPEN |=> !start_bit && sequence_error;
  endproperty
  a_need_key: assert property (p_need_key) else $error("start accepted without unlock");

  property p_pair_opens;
    s_unlock |=> key_state == FSPC_KEY_OPEN;
  endproperty
  a_pair_opens: assert property (p_pair_opens) else $error("unlock pair not accepted");

  property p_bad_key;
    wr_key && pwdata[7:0] != FSPC_KEY_FIRST && pwdata[7:0] != FSPC_KEY_SECOND |=> key_state == FSPC_KEY_NONE;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key kept progress");

  property p_enable;
    set_try && !pwdata[FSPC_BIT_PENABLE] |=> !start_bit;
  endproperty
  a_enable: assert property (p_enable) else $error("start ran with enable clear");

  property p_stall;
    start_bit |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("processor not stalled");

  property p_hold_start;
    start_bit && !op_done |=> start_bit;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("start bit dropped early");

  property p_done;
    op_done |=> !start_bit ##1 !cpu_stall;
  endproperty
  a_done: assert property (p_done) else $error("completion did not clear start");

  property p_tbl_two;
    tbl_req && !tbl_pend && !start_bit |-> ##2 tbl_ack;
  endproperty
  a_tbl_two: assert property (p_tbl_two) else $error("table op not two cycles");

  property p_row_align;
    start_bit && fl_op == FSPC_OP_ROW |-> fl_addr[6:0] == 7'h0;
  endproperty
  a_row_align: assert property (p_row_align) else $error("row address not aligned");

  property p_page_align;
    start_bit && fl_op == FSPC_OP_PAGE |-> fl_addr[9:0] == 10'h0;
  endproperty
  a_page_align: assert property (p_page_align) else $error("page address not aligned");

  property p_noop;
    start_ok && (next_op == FSPC_OP_NONE || next_op == FSPC_OP_UNIMP) |=> !fl_op_active;
  endproperty
  a_noop: assert property (p_noop) else $error("no-op code ran an operation");

  property p_key_zero;
    apb_setup && !pwrite && paddr == 32'(FSPC_OFS_KEY) |=> prdata == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key register read back");

endmodule : fspc_ctrl

// File: fspc_flash_model.sv
// flash array read port and free-running internal oscillator beside the controller
`timescale 1ns/10ps
module fspc_flash_model #(
  parameter int OSC_HALF_NS = 68
) (
  input wire logic [23:0] fl_raddr, // array read address
  output logic [23:0] fl_rdata, // array word, settles with the address
  output logic osc_in // internal oscillator, about 7.37 mhz
);
  // scrambled pattern from the low 16 address bits; addresses differing only in bits 23:16 return the same word
  assign fl_rdata = {fl_raddr[7:0] ^ 8'hc3, fl_raddr[15:0] ^ 16'h0f0f};
  initial begin
    osc_in = 1'b0;
    // small offset keeps the phase unrelated to pclk
    #3;
    forever #(OSC_HALF_NS) osc_in = ~osc_in;
  end
endmodule : fspc_flash_model

// File: fspc_ctrl_tb.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
module fspc_ctrl_tb;
  import fspc_pkg::*;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ack, cpu_stall, fl_cfg_space, fl_op_active, osc_in;
  logic [15:0] tbl_ea, tbl_wdata, tbl_rdata;
  logic [23:0] fl_raddr, fl_rdata, fl_addr, buf_rdata;
  logic [3:0] fl_op;
  logic [5:0] buf_idx;
  int n_mismatch, n_compared;
  logic [15:0] ctl_tab [14] = '{16'hc04f, 16'hc04d, 16'hc043, 16'hc042, 16'hc041, 16'hc040, 16'hc00f,
    16'hc00d, 16'hc003, 16'hc002, 16'hc001, 16'hc000, 16'hc045, 16'hc00a};
  fspc_op_t op_tab [14] = '{FSPC_OP_BULK, FSPC_OP_GENSEG, FSPC_OP_NONE, FSPC_OP_PAGE, FSPC_OP_NONE,
    FSPC_OP_CFG_ERASE, FSPC_OP_NONE, FSPC_OP_NONE, FSPC_OP_WORD, FSPC_OP_NONE, FSPC_OP_ROW,
    FSPC_OP_CFG_PROG, FSPC_OP_NONE, FSPC_OP_NONE};

  // short op counts keep the run small
  fspc_ctrl #(.ROW_OSC_CYCLES(8), .PAGE_OSC_CYCLES(8), .BULK_OSC_CYCLES(8)) DUT (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tbl_req, .tbl_write, .tbl_high, .tbl_byte, .tbl_ea, .tbl_wdata, .tbl_rdata, .tbl_ack, .cpu_stall,
    .fl_raddr, .fl_cfg_space, .fl_rdata, .fl_op_active, .fl_op, .fl_addr, .buf_idx, .buf_rdata, .osc_in
  );
  fspc_flash_model FLASH (.fl_raddr, .fl_rdata, .osc_in);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task stop_test;
    $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task timeout(input string what);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s wait ran out", $time, what);
    stop_test();
  endtask : timeout

  // entered and left just after a rising edge; one idle cycle follows each transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) timeout("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task tbl(input logic w, input logic hi, input logic byt, input logic [15:0] ea, input logic [15:0] wd,
           input logic ack);
    tbl_req <= 1'b1;
    tbl_write <= w;
    tbl_high <= hi;
    tbl_byte <= byt;
    tbl_ea <= ea;
    tbl_wdata <= wd;
    @(posedge pclk);
    tbl_req <= 1'b0;
    @(posedge pclk);
    chk(tbl_ack, 1'b0, "early table ack");
    @(posedge pclk);
    chk(tbl_ack, ack, "table ack");
  endtask : tbl

  task buf_chk(input logic [5:0] idx, input logic [23:0] exp);
    buf_idx <= idx;
    @(posedge pclk);
    @(posedge pclk);
    chk(buf_rdata, exp, "holding buffer");
  endtask : buf_chk

  task bad_start(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] ctl);
    apb(1'b1, FSPC_OFS_CONTROL, 32'h0);
    apb(1'b1, FSPC_OFS_KEY, {24'h0, k1});
    apb(1'b1, FSPC_OFS_KEY, {24'h0, k2});
    apb(1'b1, FSPC_OFS_KEY, {24'h0, FSPC_KEY_SECOND});
    apb(1'b1, FSPC_OFS_CONTROL, {16'h0, ctl});
    chk(cpu_stall, 1'b0, "refused start stalls");
    apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
    chk(rd, {16'h0, ctl ^ 16'ha000}, "refused start flags error");
  endtask : bad_start

  task run_op(input logic [15:0] ctl, input fspc_op_t op);
    int n;
    apb(1'b1, FSPC_OFS_KEY, {24'h0, FSPC_KEY_FIRST});
    apb(1'b1, FSPC_OFS_KEY, {24'h0, FSPC_KEY_SECOND});
    apb(1'b1, FSPC_OFS_CONTROL, {16'h0, ctl});
    chk(cpu_stall, op != FSPC_OP_NONE, "stall on launch");
    chk(fl_op_active, op != FSPC_OP_NONE, "array operation on launch");
    if (op != FSPC_OP_NONE) begin
      chk(fl_op, op, "operation kind");
      if (op == FSPC_OP_ROW || op == FSPC_OP_PAGE) chk(fl_addr, 24'h026000, "aligned address");
      if (op == FSPC_OP_ROW) begin
        tbl(1'b0, 1'b0, 1'b0, 16'h6000, 16'h0, 1'b0);
        apb(1'b1, FSPC_OFS_CONTROL, 32'h0);
        apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
        chk(rd, {16'h0, ctl}, "start held while running");
      end
      n = 0;
      while (cpu_stall === 1'b1 && n < 20000) begin
        @(posedge pclk);
        n++;
      end
      if (cpu_stall !== 1'b0) timeout("operation end");
      if (op == FSPC_OP_ROW) chk(n > 90 && n < 200, 1'b1, "row duration");
    end
    apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
    chk(rd, {16'h0, ctl ^ 16'h8000}, "control after operation");
  endtask : run_op

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    {presetn, por_n, psel, penable, pwrite, tbl_req, tbl_write, tbl_high, tbl_byte} = '0;
    {paddr, pwdata, tbl_ea, tbl_wdata, buf_idx} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1, "unmapped error");
    apb(1'b1, FSPC_OFS_CONTROL, 32'h7fff);
    apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
    chk(rd, 32'h604f, "unused control bits");
    chk(err, 1'b0, "mapped no error");
    apb(1'b1, FSPC_OFS_KEY, 32'hffff);
    apb(1'b0, FSPC_OFS_KEY, 32'h0);
    chk(rd, 32'h0, "key reads zero");
    apb(1'b1, FSPC_OFS_TPAGE, 32'h81);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSPC_OFS_CONTROL, 32'h0);
    chk(rd, 32'h604f, "control kept over bus reset");
    apb(1'b0, FSPC_OFS_TPAGE, 32'h0);
    chk(rd, 32'h0, "table page bus reset");
    $display("test registers done");
    apb(1'b1, FSPC_OFS_TPAGE, 32'h81);
    tbl(1'b0, 1'b0, 1'b0, 16'h6003, 16'h0, 1'b1);
    chk(fl_raddr, 24'h816002, "program address");
    chk(tbl_rdata, 16'h6f0d, "read low word");
    chk(fl_cfg_space, 1'b1, "configuration space");
    tbl(1'b0, 1'b1, 1'b0, 16'h6002, 16'h0, 1'b1);
    chk(tbl_rdata, 16'h00c1, "read high word");
    apb(1'b1, FSPC_OFS_TPAGE, 32'h02);
    for (int i = 0; i < 64; i++) begin
      tbl(1'b1, 1'b0, 1'b0, 16'h6000 + 16'(2 * i), 16'(i * 257), 1'b1);
      tbl(1'b1, 1'b1, 1'b0, 16'h6000 + 16'(2 * i), 16'(8'h80 + i), 1'b1);
    end
    chk(fl_op_active, 1'b0, "table writes leave array alone");
    chk(fl_cfg_space, 1'b0, "user space");
    for (int i = 0; i < 64; i++) buf_chk(6'(i), {8'(8'h80 + i), 16'(i * 257)});
    tbl(1'b1, 1'b0, 1'b1, 16'h6003, 16'h00ab, 1'b1);
    tbl(1'b1, 1'b1, 1'b1, 16'h6003, 16'h0077, 1'b1);
    buf_chk(6'd1, 24'h81ab01);
    $display("test table access done");
    bad_start(8'h00, 8'h00, 16'hc001);
    bad_start(8'h55, 8'h12, 16'hc001);
    bad_start(8'h00, 8'h55, 16'h8001);
    $display("test refused starts done");
    for (int i = 0; i < 14; i++) run_op(ctl_tab[i], op_tab[i]);
    $display("test operations done");
    stop_test();
  end
endmodule : fspc_ctrl_tb
